// >>> logic/ebi_core.sv
// External bus interface: cycle sequencer and pin drivers
// Function
// - Physical address is segment shifted left four plus offset, twenty bits.
// - Code segment for fetch and immediates, data for data, stack for stack and base pointer.
// - Extra segment for string destination-index operands.
// - I/O space of 64K byte ports from 8-bit or 16-bit port numbers.
// - 8-bit port numbers zero-extended, address bits 15..8 low.
// - Shared lines carry address in t1 only; address bus holds t1..t4.
// - Address bus valid half an output-clock cycle before shared-line address.
// - Address phase disable floats shared lines during address phase.
// - 8-bit variant drives address 15..8 on upper lines during data portion.
// - 8-bit disabled mode: low lines data only, upper lines address t2..t4.
// - Strap low at reset forces address on shared lines always.
// - Upper store enable low when upper-byte indicator and store strobe low.
// - Lower store enable low when address bit zero and store strobe low.
// - 8-bit variant single store enable low on every byte write.
// - Read strobe low during every read.
// - Store enables timed with the separate address bus.
// - Store strobe floats during bus grant and reset.
`timescale 1ns/10ps
`default_nettype none
module ebi_core #(
	parameter bit NARROW_BUS = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire ebi_pkg::seg_regs_t i_segs,
	input wire ebi_pkg::bus_req_t i_req,
	input wire logic i_upper_select_config_address_phase_disable,
	input wire logic i_low_select_config_address_phase_disable,
	input wire logic i_mux_address_force_strap_n,
	input wire logic i_bus_granted,
	input wire logic [ebi_pkg::OFS_W-1:0] i_ad_in,
	output logic o_req_ready,
	output logic o_rdata_valid,
	output logic [ebi_pkg::OFS_W-1:0] o_rdata,
	output logic [ebi_pkg::PHYS_W-1:0] o_addr,
	output logic [ebi_pkg::OFS_W-1:0] o_ad_out,
	output logic [ebi_pkg::OFS_W-1:0] o_ad_oe,
	output logic [ebi_pkg::PORT8_W-1:0] o_upper_address_output_lines,
	output logic o_upper_address_output_lines_oe,
	output logic o_read_strobe_n,
	output logic o_store_strobe_n,
	output logic o_store_strobe_oe,
	output logic o_upper_byte_store_enable_n,
	output logic o_lower_byte_store_enable_n,
	output logic o_byte_store_enable_n,
	output logic o_system_clock_output
);
	typedef struct packed {
		ebi_pkg::phase_t ph;
		logic last;
		logic force_mux;
		logic strap_taken;
		ebi_pkg::bus_req_t req;
		ebi_pkg::bus_pins_t pins;
		logic rdy;
		logic rvalid;
		logic [ebi_pkg::OFS_W-1:0] rdata;
	} state_t;

	localparam ebi_pkg::bus_pins_t PINS_RST = '{
		addr: ebi_pkg::ADDR_ZERO, ad_out: ebi_pkg::DATA_ZERO, ad_oe: ebi_pkg::DATA_ZERO,
		upper_addr_out: '0, upper_addr_oe: 1'b0, read_strobe_n: 1'b1,
		store_strobe_n: 1'b1, store_oe: 1'b0, upper_store_en_n: 1'b1,
		lower_store_en_n: 1'b1, byte_store_en_n: 1'b1, clk_out: 1'b0};

	state_t s_q;
	state_t s_d;
	logic [ebi_pkg::PHYS_W-1:0] phys;

	ebi_addr_gen ebi_addr_gen_i (
		.i_segs(i_segs),
		.i_req(i_req),
		.o_phys(phys)
	);

	// Address phase suppressed for a disabled space unless strap forced multiplexing
	function automatic logic addr_disabled(input ebi_pkg::bus_req_t r, input logic force_mux,
			input logic up_dis, input logic lo_dis);
		addr_disabled = !force_mux && ((r.upper_space && up_dis) || (r.low_space && lo_dis));
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic dis;
		logic wr;
		logic [ebi_pkg::OFS_W-1:0] full_oe;
		dis = 1'b0;
		wr = 1'b0;
		full_oe = NARROW_BUS ? {{ebi_pkg::PORT8_W{1'b0}}, {ebi_pkg::PORT8_W{1'b1}}}
			: {ebi_pkg::OFS_W{1'b1}};
		s_d = s_q;
		s_d.rvalid = 1'b0;
		// Strap caught on first clock after reset release
		if (!s_q.strap_taken) begin
			s_d.strap_taken = 1'b1;
			s_d.force_mux = !i_mux_address_force_strap_n;
		end
		s_d.pins.clk_out = !s_q.pins.clk_out;
		dis = addr_disabled(s_q.req, s_q.force_mux, i_upper_select_config_address_phase_disable,
			i_low_select_config_address_phase_disable);
		wr = s_q.req.write;
		unique case (s_q.ph)
			ebi_pkg::PH_IDLE: begin
				s_d.pins.ad_oe = ebi_pkg::DATA_ZERO;
				s_d.pins.read_strobe_n = 1'b1;
				s_d.pins.store_strobe_n = 1'b1;
				s_d.pins.upper_store_en_n = 1'b1;
				s_d.pins.lower_store_en_n = 1'b1;
				s_d.pins.byte_store_en_n = 1'b1;
				s_d.pins.upper_addr_oe = 1'b0;
				s_d.rdy = 1'b1;
				if (i_req.valid && s_q.rdy && !i_bus_granted && s_q.strap_taken) begin
					s_d.req = i_req;
					// Address bus leads shared-line address by one cycle
					s_d.pins.addr = phys;
					s_d.ph = ebi_pkg::PH_T1;
					s_d.rdy = 1'b0;
				end
			end
			ebi_pkg::PH_T1: begin
				// Shared lines carry address in t1 unless disabled
				s_d.pins.ad_out = s_q.pins.addr[ebi_pkg::OFS_W-1:0];
				s_d.pins.ad_oe = dis ? ebi_pkg::DATA_ZERO : full_oe;
				s_d.pins.upper_addr_out = s_q.pins.addr[ebi_pkg::OFS_W-1:ebi_pkg::PORT8_W];
				s_d.pins.upper_addr_oe = NARROW_BUS && !dis;
				s_d.ph = ebi_pkg::PH_T2;
			end
			ebi_pkg::PH_T2: begin
				// Data portion: upper lines always carry address on 8-bit bus
				s_d.pins.upper_addr_oe = NARROW_BUS;
				s_d.pins.ad_out = s_q.req.wdata;
				s_d.pins.ad_oe = wr ? full_oe : ebi_pkg::DATA_ZERO;
				s_d.pins.read_strobe_n = wr;
				s_d.pins.store_strobe_n = !wr;
				// Store enables follow store strobe, aligned with address bus
				s_d.pins.upper_store_en_n = NARROW_BUS || !wr || s_q.req.byte_hi_n;
				s_d.pins.lower_store_en_n = NARROW_BUS || !wr || s_q.pins.addr[0];
				s_d.pins.byte_store_en_n = !NARROW_BUS || !wr;
				s_d.ph = ebi_pkg::PH_T3;
				s_d.last = 1'b0;
			end
			ebi_pkg::PH_T3: begin
				// Two cycles here cover t3 and t4
				s_d.last = 1'b1;
				if (s_q.last) begin
					s_d.ph = ebi_pkg::PH_IDLE;
					s_d.rvalid = !wr;
					s_d.rdata = i_ad_in;
					s_d.pins.read_strobe_n = 1'b1;
					s_d.pins.store_strobe_n = 1'b1;
					s_d.pins.upper_store_en_n = 1'b1;
					s_d.pins.lower_store_en_n = 1'b1;
					s_d.pins.byte_store_en_n = 1'b1;
				end
			end
		endcase
		// Strobe released while another master owns the bus
		s_d.pins.store_oe = !i_bus_granted;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= '{ph: ebi_pkg::PH_IDLE, last: 1'b0, force_mux: 1'b0, strap_taken: 1'b0,
				req: '0, pins: PINS_RST, rdy: 1'b0, rvalid: 1'b0, rdata: ebi_pkg::DATA_ZERO};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs
	assign o_req_ready = s_q.rdy;
	assign o_rdata_valid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_addr = s_q.pins.addr;
	assign o_ad_out = s_q.pins.ad_out;
	assign o_ad_oe = s_q.pins.ad_oe;
	assign o_upper_address_output_lines = s_q.pins.upper_addr_out;
	assign o_upper_address_output_lines_oe = s_q.pins.upper_addr_oe;
	assign o_read_strobe_n = s_q.pins.read_strobe_n;
	assign o_store_strobe_n = s_q.pins.store_strobe_n;
	assign o_store_strobe_oe = s_q.pins.store_oe;
	assign o_upper_byte_store_enable_n = s_q.pins.upper_store_en_n;
	assign o_lower_byte_store_enable_n = s_q.pins.lower_store_en_n;
	assign o_byte_store_enable_n = s_q.pins.byte_store_en_n;
	assign o_system_clock_output = s_q.pins.clk_out;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	// Address and shared lines
	chk_addr_leads_ad: assert property (s_q.ph == ebi_pkg::PH_T1 && !dis_now()
		|=> o_ad_out == $past(o_addr[ebi_pkg::OFS_W-1:0]))
		else $error("shared-line address does not follow address bus");

	chk_addr_held: assert property (s_q.ph == ebi_pkg::PH_T2 |=> $stable(o_addr) [*3])
		else $error("address bus not held through cycle");

	chk_disable_float: assert property (s_q.ph == ebi_pkg::PH_T1 && dis_now()
		|=> o_ad_oe == ebi_pkg::DATA_ZERO)
		else $error("shared lines driven in disabled address phase");

	chk_force_mux: assert property (s_q.ph == ebi_pkg::PH_T1 && s_q.force_mux
		|=> o_ad_oe != ebi_pkg::DATA_ZERO)
		else $error("strap did not force address on shared lines");

	chk_io_upper_zero: assert property (s_q.ph == ebi_pkg::PH_T1 && s_q.req.is_io
		|-> o_addr[ebi_pkg::PHYS_W-1:ebi_pkg::OFS_W] == '0)
		else $error("port address above port space");

	chk_port8_extend: assert property (s_q.ph == ebi_pkg::PH_T1 && s_q.req.is_io
		&& s_q.req.io_port8 |-> o_addr[ebi_pkg::OFS_W-1:ebi_pkg::PORT8_W] == '0)
		else $error("short port number not zero-extended");

	chk_write_data: assert property (s_q.ph == ebi_pkg::PH_T2 && s_q.req.write
		|=> o_ad_out == s_q.req.wdata)
		else $error("write data missing in data portion");

	chk_read_release: assert property (s_q.ph == ebi_pkg::PH_T2 && !s_q.req.write
		|=> o_ad_oe == ebi_pkg::DATA_ZERO)
		else $error("shared lines driven during read data");

	// Upper lines on the 8-bit and 16-bit variants
	chk_upper_data: assert property (NARROW_BUS && s_q.ph == ebi_pkg::PH_T2
		|=> o_upper_address_output_lines_oe
		&& o_upper_address_output_lines == o_addr[ebi_pkg::OFS_W-1:ebi_pkg::PORT8_W])
		else $error("upper lines lost address in data portion");

	chk_wide_no_upper: assert property (!NARROW_BUS |-> !o_upper_address_output_lines_oe)
		else $error("upper lines driven on 16-bit variant");

	chk_narrow_low_only: assert property (NARROW_BUS && s_q.ph == ebi_pkg::PH_T1
		|=> o_ad_oe[ebi_pkg::OFS_W-1:ebi_pkg::PORT8_W] == '0)
		else $error("upper shared lines driven on 8-bit variant");

	chk_narrow_disabled: assert property (NARROW_BUS && dis_now()
		&& s_q.ph == ebi_pkg::PH_T1 |=> !o_upper_address_output_lines_oe)
		else $error("upper lines driven in disabled address phase");

	// Strobes and byte enables
	chk_upper_we: assert property (!o_store_strobe_n && !NARROW_BUS
		|-> o_upper_byte_store_enable_n == s_q.req.byte_hi_n)
		else $error("upper store enable mismatch");

	chk_lower_we: assert property (!o_store_strobe_n && !NARROW_BUS
		|-> o_lower_byte_store_enable_n == o_addr[0])
		else $error("lower store enable mismatch");

	chk_byte_we: assert property (!o_store_strobe_n && NARROW_BUS
		|-> !o_byte_store_enable_n)
		else $error("byte store enable missing");

	chk_we_addr_stable: assert property (!o_upper_byte_store_enable_n
		|| !o_lower_byte_store_enable_n || !o_byte_store_enable_n |-> $stable(o_addr))
		else $error("address moved under a store enable");

	chk_we_with_strobe: assert property (o_store_strobe_n
		|-> o_upper_byte_store_enable_n && o_lower_byte_store_enable_n
		&& o_byte_store_enable_n)
		else $error("store enable without store strobe");

	chk_read_strobe: assert property (s_q.ph == ebi_pkg::PH_T2 && !s_q.req.write
		|=> !o_read_strobe_n [*2] ##1 o_read_strobe_n)
		else $error("read strobe timing wrong");

	chk_strobes_apart: assert property (!o_read_strobe_n |-> o_store_strobe_n)
		else $error("read and store strobes together");

	chk_rvalid_read: assert property (o_rdata_valid |-> !s_q.req.write)
		else $error("read data flagged on a write");

	// Clock output, handshake and bus grant
	chk_clock_out: assert property (s_q.strap_taken
		|-> o_system_clock_output != $past(o_system_clock_output))
		else $error("clock output did not toggle");

	chk_busy: assert property (s_q.ph != ebi_pkg::PH_IDLE |-> !o_req_ready)
		else $error("ready raised inside a bus cycle");

	chk_grant_float: assert property (i_bus_granted |=> !o_store_strobe_oe)
		else $error("store strobe driven during grant");

	chk_grant_hold: assert property (i_bus_granted && s_q.ph == ebi_pkg::PH_IDLE
		|=> s_q.ph == ebi_pkg::PH_IDLE)
		else $error("bus cycle started while granted away");

	cov_read: cover property (s_q.ph == ebi_pkg::PH_T3 && s_q.last && !s_q.req.write);
	cov_write: cover property (!o_store_strobe_n);
	cov_disabled: cover property (s_q.ph == ebi_pkg::PH_T1 && dis_now());
	cov_forced: cover property (s_q.ph == ebi_pkg::PH_T1 && s_q.force_mux);
	cov_narrow_write: cover property (NARROW_BUS && !o_byte_store_enable_n);

	function automatic logic dis_now();
		dis_now = addr_disabled(s_q.req, s_q.force_mux,
			i_upper_select_config_address_phase_disable, i_low_select_config_address_phase_disable);
	endfunction
endmodule // ebi_core
`default_nettype wire

// >>> logic/ebi_pkg.sv
// Package: constants and carrier types for the external bus interface
package ebi_pkg;
	localparam int SEG_SHIFT = 4;
	localparam int PHYS_W = 20;
	localparam int OFS_W = 16;
	localparam int PORT8_W = 8;
	localparam logic [1:0] SEG_CODE = 2'h0;
	localparam logic [1:0] SEG_DATA = 2'h1;
	localparam logic [1:0] SEG_STACK = 2'h2;
	localparam logic [1:0] SEG_EXTRA = 2'h3;
	localparam logic [PHYS_W-1:0] ADDR_ZERO = 20'h00000;
	localparam logic [OFS_W-1:0] DATA_ZERO = 16'h0000;

	// Kind of reference that drives implicit segment choice
	typedef enum logic [2:0] {
		REF_FETCH = 3'h0,
		REF_IMM = 3'h1,
		REF_DATA = 3'h2,
		REF_STACK = 3'h3,
		REF_BASE_POINTER = 3'h4,
		REF_STR_DEST = 3'h5
	} ref_kind_t;

	// Bus cycle phases t1..t4, Gray along the path
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_T1 = 2'h1,
		PH_T2 = 2'h3,
		PH_T3 = 2'h2
	} phase_t;

	typedef struct packed {
		logic [OFS_W-1:0] code_segment;
		logic [OFS_W-1:0] data_segment;
		logic [OFS_W-1:0] stack_segment;
		logic [OFS_W-1:0] extra_segment;
	} seg_regs_t;

	typedef struct packed {
		logic valid;
		logic is_io;
		logic io_port8;
		logic write;
		logic byte_hi_n;
		ref_kind_t kind;
		logic [OFS_W-1:0] offset;
		logic [OFS_W-1:0] wdata;
		logic upper_space;
		logic low_space;
	} bus_req_t;

	typedef struct packed {
		logic [PHYS_W-1:0] addr;
		logic [OFS_W-1:0] ad_out;
		logic [OFS_W-1:0] ad_oe;
		logic [PORT8_W-1:0] upper_addr_out;
		logic upper_addr_oe;
		logic read_strobe_n;
		logic store_strobe_n;
		logic store_oe;
		logic upper_store_en_n;
		logic lower_store_en_n;
		logic byte_store_en_n;
		logic clk_out;
	} bus_pins_t;
endpackage

// >>> logic/ebi_addr_gen.sv
// Physical address generator with implicit segment choice
`timescale 1ns/10ps
`default_nettype none
module ebi_addr_gen (
	input wire ebi_pkg::seg_regs_t i_segs,
	input wire ebi_pkg::bus_req_t i_req,
	output logic [ebi_pkg::PHYS_W-1:0] o_phys
);
	logic [1:0] seg_sel;
	logic [ebi_pkg::OFS_W-1:0] seg_val;
	logic [ebi_pkg::OFS_W-1:0] port;

	// ==========================================
	// Segment selection
	always_comb begin
		unique case (i_req.kind)
			ebi_pkg::REF_FETCH, ebi_pkg::REF_IMM: seg_sel = ebi_pkg::SEG_CODE;
			ebi_pkg::REF_STACK,
			ebi_pkg::REF_BASE_POINTER: seg_sel = ebi_pkg::SEG_STACK;
			ebi_pkg::REF_STR_DEST: seg_sel = ebi_pkg::SEG_EXTRA;
			default: seg_sel = ebi_pkg::SEG_DATA;
		endcase
		unique case (seg_sel)
			ebi_pkg::SEG_CODE: seg_val = i_segs.code_segment;
			ebi_pkg::SEG_STACK: seg_val = i_segs.stack_segment;
			ebi_pkg::SEG_EXTRA: seg_val = i_segs.extra_segment;
			default: seg_val = i_segs.data_segment;
		endcase
	end

	// ==========================================
	// Address arithmetic
	always_comb begin
		// Immediate port numbers zero-extend: high byte low
		port = i_req.io_port8 ?
			{{(ebi_pkg::OFS_W-ebi_pkg::PORT8_W){1'b0}}, i_req.offset[ebi_pkg::PORT8_W-1:0]}
			: i_req.offset;
		if (i_req.is_io) begin
			o_phys = {{(ebi_pkg::PHYS_W-ebi_pkg::OFS_W){1'b0}}, port};
		end else begin
			o_phys = ({seg_val, {ebi_pkg::SEG_SHIFT{1'b0}}}
				+ {{(ebi_pkg::PHYS_W-ebi_pkg::OFS_W){1'b0}}, i_req.offset});
		end
	end
endmodule // ebi_addr_gen
`default_nettype wire

// >>> sim/ebi_mem_model.sv
// Behavioural external static memory on the shared address/data lines
`timescale 1ns/10ps
`default_nettype none
module ebi_mem_model (
	input wire logic i_sys_clk,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_ad_out,
	input wire logic i_read_strobe_n,
	input wire logic i_store_strobe_n,
	input wire logic i_upper_byte_store_enable_n,
	input wire logic i_lower_byte_store_enable_n,
	output logic [15:0] o_ad_in
);
	logic [15:0] mem_q [0:15];
	logic [15:0] last_q = 16'h0000;

	// ========================================
	// Read side
	// Released lines show the inverse of the last value, so stale data cannot match
	assign o_ad_in = !i_read_strobe_n ? mem_q[i_addr[4:1]] : ~last_q;

	// ========================================
	// Store side, one byte lane per enable
	always @(posedge i_sys_clk) begin
		if (!i_read_strobe_n)
			last_q <= mem_q[i_addr[4:1]];
		if (!i_store_strobe_n && !i_upper_byte_store_enable_n)
			mem_q[i_addr[4:1]][15:8] <= i_ad_out[15:8];
		if (!i_store_strobe_n && !i_lower_byte_store_enable_n)
			mem_q[i_addr[4:1]][7:0] <= i_ad_out[7:0];
	end
endmodule // ebi_mem_model
`default_nettype wire

// >>> sim/test_external_bus_interface.sv
// Self-checking testbench for the external bus interface core
`timescale 1ns/10ps
`default_nettype none
module test_external_bus_interface;
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] ad;
		logic [15:0] oe;
		logic [15:0] noe;
		logic [7:0] up;
		logic upoe, rd, st, hi, lo, bse, rdy;
	} snap_t;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_mux_address_force_strap_n = 1'b1;
	logic i_bus_granted = 1'b0;
	logic i_upper_select_config_address_phase_disable = 1'b0;
	logic i_low_select_config_address_phase_disable = 1'b0;
	ebi_pkg::seg_regs_t i_segs = '0;
	ebi_pkg::bus_req_t i_req = '0;
	wire logic [15:0] i_ad_in, o_rdata, o_ad_out, o_ad_oe, n_oe;
	wire logic [19:0] o_addr;
	wire logic [7:0] n_up;
	wire logic o_req_ready, o_rdata_valid, o_read_strobe_n, o_store_strobe_n, o_store_strobe_oe;
	wire logic o_upper_byte_store_enable_n, o_lower_byte_store_enable_n, n_upoe, n_bse;
	wire logic o_system_clock_output;
	snap_t s [1:5];
	int n_errors = 0;
	int total_checks = 0;

	ebi_core #(.NARROW_BUS(1'b0)) ebi_core_i (.i_sys_clk, .i_resetn, .i_segs, .i_req,
		.i_upper_select_config_address_phase_disable,
		.i_low_select_config_address_phase_disable,
		.i_mux_address_force_strap_n, .i_bus_granted, .i_ad_in, .o_req_ready,
		.o_rdata_valid, .o_rdata, .o_addr, .o_ad_out, .o_ad_oe,
		.o_upper_address_output_lines(), .o_upper_address_output_lines_oe(),
		.o_read_strobe_n, .o_store_strobe_n, .o_store_strobe_oe,
		.o_upper_byte_store_enable_n, .o_lower_byte_store_enable_n,
		.o_byte_store_enable_n(), .o_system_clock_output);
	// Narrow variant sees the same requests; only its own pins are judged
	ebi_core #(.NARROW_BUS(1'b1)) ebi_core_narrow_i (.i_sys_clk, .i_resetn, .i_segs, .i_req,
		.i_upper_select_config_address_phase_disable,
		.i_low_select_config_address_phase_disable,
		.i_mux_address_force_strap_n, .i_bus_granted, .i_ad_in, .o_req_ready(),
		.o_rdata_valid(), .o_rdata(), .o_addr(), .o_ad_out(), .o_ad_oe(n_oe),
		.o_upper_address_output_lines(n_up), .o_upper_address_output_lines_oe(n_upoe),
		.o_read_strobe_n(), .o_store_strobe_n(), .o_store_strobe_oe(),
		.o_upper_byte_store_enable_n(), .o_lower_byte_store_enable_n(),
		.o_byte_store_enable_n(n_bse), .o_system_clock_output());
	ebi_mem_model ebi_mem_model_i (.i_sys_clk, .i_addr(o_addr), .i_ad_out(o_ad_out),
		.i_read_strobe_n(o_read_strobe_n), .i_store_strobe_n(o_store_strobe_n),
		.i_upper_byte_store_enable_n(o_upper_byte_store_enable_n),
		.i_lower_byte_store_enable_n(o_lower_byte_store_enable_n), .o_ad_in(i_ad_in));

	always #10 i_sys_clk = ~i_sys_clk;

	// ========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset(input logic strap_n);
		@(negedge i_sys_clk);
		i_resetn = 1'b0;
		i_mux_address_force_strap_n = strap_n;
		repeat (8) @(negedge i_sys_clk);
		check(o_store_strobe_oe, 1'b0);
		i_resetn = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		i_mux_address_force_strap_n = 1'b1;
	endtask

	// One transfer; s[k] holds the pins after the k-th edge, counting the take edge as the first
	task automatic run(input ebi_pkg::bus_req_t r);
		int k;
		k = 0;
		@(negedge i_sys_clk);
		while (o_req_ready !== 1'b1 && k < 20) begin
			@(negedge i_sys_clk);
			k++;
		end
		i_req = r;
		@(posedge i_sys_clk);
		for (k = 1; k <= 5; k++) begin
			@(negedge i_sys_clk);
			i_req.valid = 1'b0;
			s[k] = '{o_addr, o_ad_out, o_ad_oe, n_oe, n_up, n_upoe, o_read_strobe_n,
				o_store_strobe_n, o_upper_byte_store_enable_n,
				o_lower_byte_store_enable_n, n_bse, o_req_ready};
		end
	endtask

	task automatic wr(input logic [15:0] off, input logic [15:0] data, input logic hi_n,
		input logic exp_hi, input logic exp_lo);
		ebi_pkg::bus_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.write = 1'b1;
		r.kind = ebi_pkg::REF_DATA;
		r.offset = off;
		r.wdata = data;
		r.byte_hi_n = hi_n;
		run(r);
		check({s[3].hi, s[3].lo}, {exp_hi, exp_lo});
		check({s[3].bse, s[3].ad}, {1'b0, data});
		check({s[5].st, s[3].st, s[4].addr}, {2'h2, 4'h0, off});
		check({s[3].upoe, s[3].up}, {1'b1, off[15:8]});
	endtask

	// ========================================
	// Scenarios
	task automatic t_segments;
		ebi_pkg::bus_req_t r;
		logic [15:0] sg;
		r = '0;
		r.valid = 1'b1;
		i_segs = '{16'h1234, 16'h2000, 16'h3000, 16'hFFFF};
		for (int i = 0; i < 6; i++) begin
			r.kind = ebi_pkg::ref_kind_t'(i);
			r.offset = 16'h0F00 + 16'(i * 48);
			sg = (i < 2) ? 16'h1234 : (i == 2) ? 16'h2000 : (i < 5) ? 16'h3000 : 16'hFFFF;
			run(r);
			check(s[1].addr, 20'({sg, 4'h0} + {4'h0, r.offset}));
			check({s[1].rdy, s[5].addr}, {1'b0, s[1].addr});
		end
		r.is_io = 1'b1;
		r.offset = 16'hABCD;
		for (int i = 0; i < 2; i++) begin
			r.io_port8 = i[0];
			run(r);
			check(s[1].addr, i ? 20'h000CD : 20'h0ABCD);
		end
	endtask

	task automatic t_write_read;
		ebi_pkg::bus_req_t r;
		i_segs = '0;
		wr(16'h0008, 16'h1111, 1'b0, 1'b0, 1'b0);
		wr(16'h0009, 16'hAB55, 1'b0, 1'b0, 1'b1);
		wr(16'h0008, 16'h66CD, 1'b1, 1'b1, 1'b0);
		r = '0;
		r.valid = 1'b1;
		r.offset = 16'h0008;
		run(r);
		check({s[2].ad, s[2].oe}, {16'h0008, 16'hFFFF});
		check({s[3].rd, s[5].rd, s[3].st}, 3'h3);
		check({o_rdata_valid, o_rdata}, {1'b1, 16'hABCD});
	endtask

	task automatic t_disable;
		ebi_pkg::bus_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.offset = 16'h5A08;
		i_upper_select_config_address_phase_disable = 1'b1;
		i_low_select_config_address_phase_disable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			r.upper_space = (i != 1);
			r.low_space = (i == 1);
			if (i == 2)
				do_reset(1'b0);
			run(r);
			check(s[2].oe, (i == 2) ? 16'hFFFF : 16'h0000);
			check({s[2].upoe, s[2].noe[7:0]}, (i == 2) ? 9'h1FF : 9'h000);
			check({s[3].upoe, s[4].up}, 9'h15A);
		end
	endtask

	task automatic t_grant;
		logic co;
		@(negedge i_sys_clk);
		i_bus_granted = 1'b1;
		i_req.valid = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		check({o_store_strobe_oe, o_req_ready}, 2'h1);
		co = o_system_clock_output;
		i_req.valid = 1'b0;
		i_bus_granted = 1'b0;
		@(negedge i_sys_clk);
		check(o_store_strobe_oe, 1'b1);
		check(o_system_clock_output, !co);
	endtask

	// ========================================
	// Main sequence and watchdog
	initial begin
		do_reset(1'b1);
		t_segments();
		t_write_read();
		t_disable();
		t_grant();
		finish_test();
	end

	// Whole run is well under a thousand cycles
	initial begin
		#100000;
		n_errors++;
		finish_test();
	end
endmodule // test_external_bus_interface
`default_nettype wire
